// ===== capture_compare_pkg.sv
// shared constants for the capture/compare channel
package capture_compare_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] addr_low_byte = 8'h00;
    localparam logic [7:0] addr_high_byte = 8'h04;
    localparam logic [7:0] addr_control = 8'h08;
    localparam logic [7:0] addr_status = 8'h0C;
    localparam logic [7:0] addr_timer_select = 8'h10;
    // reset values
    localparam logic [5:0] control_reset = 6'h00;
    localparam logic [15:0] value_reset = 16'h0000;
    // mode field codes
    localparam logic [3:0] mode_off = 4'h0;
    localparam logic [3:0] mode_cmp_toggle = 4'h2;
    localparam logic [3:0] mode_cap_can = 4'h3;
    localparam logic [3:0] mode_cap_fall = 4'h4;
    localparam logic [3:0] mode_cap_rise = 4'h5;
    localparam logic [3:0] mode_cap_rise4 = 4'h6;
    localparam logic [3:0] mode_cap_rise16 = 4'h7;
    localparam logic [3:0] mode_cmp_set = 4'h8;
    localparam logic [3:0] mode_cmp_clear = 4'h9;
    localparam logic [3:0] mode_cmp_soft = 4'hA;
    localparam logic [3:0] mode_cmp_trigger = 4'hB;
    // prescaler terminal counts (count minus one)
    localparam logic [3:0] presc_last4 = 4'h3;
    localparam logic [3:0] presc_last16 = 4'hF;
    // field positions
    localparam int mode_lsb = 0;
    localparam int mode_msb = 3;
    localparam int flag_bit = 0;
    localparam int enable_bit = 1;
    localparam int timer_sel_bit = 0;
    localparam int can_cap_bit = 1;
    localparam int pin_level_bit = 2;
    localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage : capture_compare_pkg

// ===== pin_synchronizer.sv
// three-stage synchronizer with agreement filter for one pin
`timescale 1ns/1ps
module pin_synchronizer (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic pin_async,
    output logic pin_level
);
    logic stage_one;
    logic stage_two;
    logic stage_three;

    // first stage feeds only the second; level updates when 2 and 3 agree
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage_one <= 1'b0;
            stage_two <= 1'b0;
            stage_three <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            stage_one <= pin_async;
            stage_two <= stage_one;
            stage_three <= stage_two;
            if (stage_two == stage_three) begin
                pin_level <= stage_three;
            end
        end
    end
endmodule : pin_synchronizer

// ===== capture_compare_unit.sv
// capture/compare channel with an ahb-lite register slave
// How it works
// - value held as low and high bytes plus control register, all rw
// - timer one or three is the capture and compare time base
// - capture copies the full 16-bit selected timer count on an event
// - mode selects falling, rising, every 4th or every 16th rising edge
// - each capture sets the irq flag; only software clears it
// - a new capture overwrites the old value without any flag
// - pin driven as output still feeds edge detection as capture events
// - a select bit chooses timer one or timer three for this channel
// - prescaler clears when off, outside capture mode, or on reset
// - switching prescaler modes directly keeps the prescaler count
// - can receive strobe rising edge serves as a timestamp event
// - can capture enable takes events from can strobe, not the pin
// - compare mode matches the value against selected timer count
// - match drives pin high, low, toggles or holds; sets flag same cycle
// - writing zero to control forces the compare latch low
// - soft interrupt compare mode leaves the pin and raises irq only
// - trigger mode match pulses a reset to the selected timer
// - enhanced channel trigger also starts conversion if converter on
// - trigger reset does not set the timer overflow flags
// - capture codes 0100, 0101, 0110, 0111 and 0011 for can events
// - compare codes 0010, 1000, 1001, 1010, 1011; 0000 is off
// - a software timer three write beats a coinciding trigger reset
`timescale 1ns/1ps
module capture_compare_unit
    import capture_compare_pkg::*;
#(
    parameter int timer_width = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic channel_pin_in,
    input wire logic [15:0] timer_one_count,
    input wire logic [15:0] timer_three_count,
    input wire logic timer_three_sw_write,
    input wire logic can_rx_strobe,
    input wire logic adc_enabled,
    output logic channel_pin_out,
    output logic channel_irq,
    output logic timer_one_reset,
    output logic timer_three_reset,
    output logic adc_start
);
    initial begin
        if (timer_width != 16) begin
            $error("timer_width must be 16");
        end
    end

    logic [7:0] capture_compare_low_byte;
    logic [7:0] capture_compare_high_byte;
    logic [5:0] channel_control;
    logic channel_irq_flag;
    logic channel_irq_enable;
    logic timer_select;
    logic can_capture_enable;
    logic [3:0] presc_count;
    logic pin_sync;
    logic pin_prev;
    logic can_prev;
    logic match_prev;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;

    // bus address phase decode
    wire bus_take = hsel && hready && (htrans == htrans_nonseq);
    wire wr_low = ap_valid && ap_write && (ap_addr == addr_low_byte);
    wire wr_high = ap_valid && ap_write && (ap_addr == addr_high_byte);
    wire wr_ctrl = ap_valid && ap_write && (ap_addr == addr_control);
    wire wr_stat = ap_valid && ap_write && (ap_addr == addr_status);
    wire wr_tsel = ap_valid && ap_write && (ap_addr == addr_timer_select);

    // mode decode
    wire [3:0] channel_mode_field = channel_control[mode_msb:mode_lsb];
    wire [3:0] next_mode = hwdata[mode_msb:mode_lsb];
    wire cap_fall = (channel_mode_field == mode_cap_fall);
    wire cap_rise = (channel_mode_field == mode_cap_rise);
    wire cap_r4 = (channel_mode_field == mode_cap_rise4);
    wire cap_r16 = (channel_mode_field == mode_cap_rise16);
    wire cap_can = (channel_mode_field == mode_cap_can);
    wire cap_mode = cap_fall || cap_rise || cap_r4 || cap_r16 || cap_can;
    wire cmp_toggle = (channel_mode_field == mode_cmp_toggle);
    wire cmp_set = (channel_mode_field == mode_cmp_set);
    wire cmp_clr = (channel_mode_field == mode_cmp_clear);
    wire cmp_soft = (channel_mode_field == mode_cmp_soft);
    wire cmp_trig = (channel_mode_field == mode_cmp_trigger);
    wire cmp_mode = cmp_toggle || cmp_set || cmp_clr || cmp_soft || cmp_trig;

    wire [15:0] time_base = timer_select ? timer_three_count : timer_one_count;
    wire [15:0] capture_compare_value =
        {capture_compare_high_byte, capture_compare_low_byte};

    // pin crosses four flops before edge detection
    pin_synchronizer pin_sync_inst (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_async(channel_pin_in),
        .pin_level(pin_sync)
    );

    // event source: can strobe replaces the pin when enabled
    wire src_rise = can_capture_enable ? (can_rx_strobe && !can_prev)
                                       : (pin_sync && !pin_prev);
    wire src_fall = !can_capture_enable && !pin_sync && pin_prev;
    // edge qualification with prescaler terminal counts
    wire presc_hit4 = (presc_count[1:0] == presc_last4[1:0]);
    wire presc_hit16 = (presc_count == presc_last16);
    wire capture_event = (cap_fall && src_fall)
        || ((cap_rise || cap_can) && src_rise)
        || (cap_r4 && src_rise && presc_hit4)
        || (cap_r16 && src_rise && presc_hit16);

    // full-width equality, one report per equality episode
    wire equal_now = (time_base == capture_compare_value);
    wire compare_match = cmp_mode && equal_now && !match_prev;

    // flag set sources; set wins over a software clear
    wire flag_set = capture_event || compare_match;
    wire flag_clear = wr_stat && !hwdata[flag_bit];

    // bus address phase capture
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_valid <= bus_take;
            ap_write <= hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    // value bytes: capture overwrites, bus write otherwise
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            capture_compare_low_byte <= value_reset[7:0];
            capture_compare_high_byte <= value_reset[15:8];
        end else if (capture_event) begin
            capture_compare_low_byte <= time_base[7:0];
            capture_compare_high_byte <= time_base[15:8];
        end else begin
            if (wr_low) begin
                capture_compare_low_byte <= hwdata[7:0];
            end
            if (wr_high) begin
                capture_compare_high_byte <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            channel_control <= control_reset;
            channel_irq_enable <= 1'b0;
            timer_select <= 1'b0;
            can_capture_enable <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                channel_control <= hwdata[5:0];
            end
            if (wr_stat) begin
                channel_irq_enable <= hwdata[enable_bit];
            end
            if (wr_tsel) begin
                timer_select <= hwdata[timer_sel_bit];
                can_capture_enable <= hwdata[can_cap_bit];
            end
        end
    end

    // sticky flag, hardware only sets it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            channel_irq_flag <= 1'b0;
        end else if (flag_set) begin
            channel_irq_flag <= 1'b1;
        end else if (flag_clear) begin
            channel_irq_flag <= 1'b0;
        end
    end

    // prescaler: cleared off or outside capture, kept otherwise
    always_ff @(posedge ref_clk) begin
        if (!nrst || !cap_mode) begin
            presc_count <= 4'h0;
        end else if (src_rise && (cap_r4 || cap_r16)) begin
            presc_count <= presc_count + 4'h1;
        end
    end

    // edge history; pin follows whatever drives it, output or not
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_prev <= 1'b0;
            can_prev <= 1'b0;
            match_prev <= 1'b0;
        end else begin
            pin_prev <= pin_sync;
            can_prev <= can_rx_strobe;
            match_prev <= cmp_mode && equal_now;
        end
    end

    // compare output latch
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            channel_pin_out <= 1'b0;
        end else if (wr_ctrl && (next_mode == mode_off)) begin
            channel_pin_out <= 1'b0;
        end else if (wr_ctrl && (next_mode == mode_cmp_set)) begin
            channel_pin_out <= 1'b0;
        end else if (wr_ctrl && (next_mode == mode_cmp_clear)) begin
            channel_pin_out <= 1'b1;
        end else if (compare_match) begin
            // pin action on match; soft and trigger hold
            if (cmp_set) begin
                channel_pin_out <= 1'b1;
            end else if (cmp_clr) begin
                channel_pin_out <= 1'b0;
            end else if (cmp_toggle) begin
                channel_pin_out <= !channel_pin_out;
            end
        end
    end

    // trigger pulses; sw write to timer three wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            timer_one_reset <= 1'b0;
            timer_three_reset <= 1'b0;
            adc_start <= 1'b0;
            channel_irq <= 1'b0;
        end else begin
            timer_one_reset <= compare_match && cmp_trig && !timer_select;
            timer_three_reset <= compare_match && cmp_trig && timer_select
                && !timer_three_sw_write;
            // conversion start only while converter enabled
            adc_start <= compare_match && cmp_trig && adc_enabled;
            channel_irq <= (channel_irq_flag || flag_set) && channel_irq_enable;
        end
    end

    // read mux on the address phase so data stands through the data phase
    wire [7:0] rd_addr = haddr[7:0];
    wire [31:0] rd_mux =
        (rd_addr == addr_low_byte) ? {24'h000000, capture_compare_low_byte} :
        (rd_addr == addr_high_byte) ? {24'h000000, capture_compare_high_byte} :
        (rd_addr == addr_control) ? {26'h0000000, channel_control} :
        (rd_addr == addr_status) ? {29'h00000000, pin_sync,
            channel_irq_enable, channel_irq_flag} :
        (rd_addr == addr_timer_select) ? {30'h00000000,
            can_capture_enable, timer_select} : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (bus_take && !hwrite) ? rd_mux : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule : capture_compare_unit

// ===== capture_compare_props.sv
// port checker for the capture/compare channel
`timescale 1ns/1ps
module capture_compare_props
    import capture_compare_pkg::*;
#(
    parameter int timer_width = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic channel_pin_out,
    input wire logic channel_irq,
    input wire logic timer_one_reset,
    input wire logic timer_three_reset
);
    logic wp;
    logic [7:0] wa;
    logic t3_sel;
    // a write that may legally drop the request: status or control
    wire clr_ph = wp && (wa == addr_status || wa == addr_control);
    wire trig = timer_one_reset || timer_three_reset;
    // follow bus writes so the selected time base is known
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wp <= 1'b0;
            wa <= 8'h00;
            t3_sel <= 1'b0;
        end else begin
            wp <= hsel && hready && htrans == htrans_nonseq && hwrite;
            wa <= haddr[7:0];
            if (wp && wa == addr_timer_select)
                t3_sel <= hwdata[timer_sel_bit];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_zero_wait: assert property (hreadyout)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!hresp)
        else $error("slave gave an error response");
    a_single_trigger: assert property (!(timer_one_reset && timer_three_reset))
        else $error("both timers reset at once");
    a_t1_when_sel: assert property (timer_one_reset |-> !t3_sel)
        else $error("timer one reset while timer three selected");
    a_t3_when_sel: assert property (timer_three_reset |-> t3_sel)
        else $error("timer three reset while timer one selected");
    a_trig_once: assert property (trig |=> !trig)
        else $error("trigger held longer than one cycle");
    a_irq_sticky: assert property ($fell(channel_irq) |->
        $past(clr_ph) || $past(clr_ph, 2))
        else $error("request dropped without a software write");
    a_reset_low: assert property (disable iff (1'b0)
        !nrst |=> !channel_pin_out && !channel_irq)
        else $error("pin or request not low after reset");
endmodule : capture_compare_props

bind capture_compare_unit capture_compare_props #(
    .timer_width(timer_width)
) u_props (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .channel_pin_out(channel_pin_out),
    .channel_irq(channel_irq), .timer_one_reset(timer_one_reset),
    .timer_three_reset(timer_three_reset)
);

// ===== far_side_model.sv
// far side: timers one and three, the capture pin and the can strobe
`timescale 1ns/1ps
module far_side_model (
    input wire logic ref_clk,
    input wire logic timer_one_reset,
    input wire logic timer_three_reset,
    output logic [15:0] timer_one_count,
    output logic [15:0] timer_three_count,
    output logic timer_three_sw_write,
    output logic channel_pin_in,
    output logic can_rx_strobe
);
    logic run;
    logic [15:0] load_val;
    // idle state at time zero
    initial begin
        {run, timer_three_sw_write, channel_pin_in, can_rx_strobe} = 4'h0;
        {load_val, timer_one_count, timer_three_count} = 48'h0;
    end
    // software load beats a trigger reset
    always @(posedge ref_clk) begin
        if (timer_three_sw_write) begin
            timer_one_count <= load_val;
            timer_three_count <= ~load_val;
        end else begin
            timer_one_count <= timer_one_reset ? 16'h0 :
                timer_one_count + 16'(run);
            timer_three_count <= timer_three_reset ? 16'h0 :
                timer_three_count + 16'(run);
        end
    end
    // load both timers; timer three gets the inverse so they differ
    task set_timers(input logic [15:0] v, input logic go);
        @(posedge ref_clk);
        timer_three_sw_write <= 1'b1;
        load_val <= v;
        run <= go;
        @(posedge ref_clk);
        timer_three_sw_write <= 1'b0;
    endtask : set_timers
    // pin pulses, long enough to pass the synchronizer
    task pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            channel_pin_in <= 1'b1;
            repeat (8) @(posedge ref_clk);
            channel_pin_in <= 1'b0;
            repeat (8) @(posedge ref_clk);
        end
    endtask : pulses
    // one received message is one rising strobe
    task can_event;
        @(posedge ref_clk);
        can_rx_strobe <= 1'b1;
        repeat (4) @(posedge ref_clk);
        can_rx_strobe <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : can_event
endmodule : far_side_model

// ===== capture_compare_unit_tb_top.sv
// self-checking bench for the capture/compare channel
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    fails++; $display("BAD %0t got %h want %h", $time, a, b); end end
module capture_compare_unit_tb_top
    import capture_compare_pkg::*;
;
    logic ref_clk, nrst, hsel, hwrite, adc_enabled, sel, pb, f;
    logic [31:0] haddr, hwdata, hrdata, d, r;
    logic [1:0] htrans;
    logic hreadyout, hresp, pin_out, irq, t1_rst, t3_rst, adc_go;
    logic pin_in, can_rx, t3_wr;
    logic [15:0] t1, t3, v, tv;
    int fails = 0, check_count = 0, cyc = 0, adc_cnt = 0, a0;
    logic [3:0] cap_m [4] = '{mode_cap_rise16, mode_cap_rise4,
        mode_cap_fall, mode_cap_rise};
    int cap_n [4] = '{16, 4, 1, 1};
    logic [3:0] cmp_m [5] = '{mode_cmp_set, mode_cmp_clear,
        mode_cmp_toggle, mode_cmp_soft, mode_cmp_trigger};
    capture_compare_unit DUT (
        .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .channel_pin_in(pin_in), .timer_one_count(t1),
        .timer_three_count(t3), .timer_three_sw_write(t3_wr),
        .can_rx_strobe(can_rx), .adc_enabled(adc_enabled),
        .channel_pin_out(pin_out), .channel_irq(irq),
        .timer_one_reset(t1_rst), .timer_three_reset(t3_rst),
        .adc_start(adc_go));
    far_side_model far (
        .ref_clk(ref_clk), .timer_one_reset(t1_rst),
        .timer_three_reset(t3_rst), .timer_one_count(t1),
        .timer_three_count(t3), .timer_three_sw_write(t3_wr),
        .channel_pin_in(pin_in), .can_rx_strobe(can_rx));
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // pin level expected after a compare match
    function automatic logic exp_pin(input logic [3:0] m, input logic p);
        case (m)
            mode_cmp_set: return 1'b1;
            mode_cmp_clear: return 1'b0;
            mode_cmp_toggle: return ~p;
            default: return p;
        endcase
    endfunction : exp_pin
    // one single ahb-lite transfer; read data taken at the data edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] q);
        @(posedge ref_clk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, htrans_nonseq, 24'h0, a};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata;
    endtask : bus
    task cap_check(input logic [15:0] e);
        bus(1'b0, addr_status, 32'h0, d);
        `CHK(d[0], 1'b1)
        bus(1'b0, addr_low_byte, 32'h0, d);
        `CHK(d[7:0], e[7:0])
        bus(1'b0, addr_high_byte, 32'h0, d);
        `CHK(d[7:0], e[15:8])
    endtask : cap_check
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // hang guard, well above the thousand or so cycles the run needs
    // count conversion start pulses so the bench can compare per match
    always @(posedge ref_clk) begin
        if (adc_go === 1'b1) adc_cnt++;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        {nrst, hsel, hwrite, adc_enabled, htrans} = 6'h0;
        {haddr, hwdata, r} = {64'h0, 32'hEB86};
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        bus(1'b0, addr_control, 32'h0, d);
        `CHK(d, 32'h0)
        bus(1'b1, addr_low_byte, 32'hA5, d);
        bus(1'b1, addr_high_byte, 32'h3C, d);
        bus(1'b1, addr_control, 32'h3A, d);
        bus(1'b0, addr_low_byte, 32'h0, d);
        `CHK(d, 32'hA5)
        bus(1'b0, addr_high_byte, 32'h0, d);
        `CHK(d, 32'h3C)
        bus(1'b0, addr_control, 32'h0, d);
        `CHK(d, 32'h3A)
        bus(1'b0, 8'h20, 32'h0, d);
        `CHK(d, 32'h0)
        $display("register test done");
        // control cleared first so the prescaler restarts from zero
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            sel = r[16];
            bus(1'b1, addr_timer_select, {31'h0, sel}, d);
            bus(1'b1, addr_control, 32'h0, d);
            far.set_timers(r[15:0], 1'b0);
            bus(1'b1, addr_control, {28'h0, cap_m[i]}, d);
            // clear the flag left by the previous capture
            bus(1'b1, addr_status, 32'h2, d);
            far.pulses(cap_n[i] - 1);
            bus(1'b0, addr_status, 32'h0, d);
            `CHK(d[0], 1'b0)
            far.pulses(1);
            cap_check(sel ? ~r[15:0] : r[15:0]);
        end
        r = lfsr(r);
        far.set_timers(r[15:0], 1'b0);
        far.pulses(1);
        cap_check(sel ? ~r[15:0] : r[15:0]);
        bus(1'b1, addr_timer_select, 32'h2, d);
        bus(1'b1, addr_control, 32'h0, d);
        bus(1'b1, addr_control, {28'h0, mode_cap_can}, d);
        bus(1'b1, addr_status, 32'h2, d);
        far.pulses(1);
        bus(1'b0, addr_status, 32'h0, d);
        `CHK(d[0], 1'b0)
        far.can_event();
        cap_check(r[15:0]);
        $display("capture test done");
        for (int i = 0; i < 5; i++) begin
            r = lfsr(r);
            sel = r[16];
            adc_enabled <= r[17];
            v = {1'b0, r[14:0]} | 16'h0100;
            tv = sel ? ~(v - 16'd30) : v - 16'd30;
            bus(1'b1, addr_timer_select, {31'h0, sel}, d);
            bus(1'b1, addr_control, 32'h0, d);
            bus(1'b1, addr_status, 32'h2, d);
            `CHK(pin_out, 1'b0)
            far.set_timers(tv, 1'b0);
            bus(1'b1, addr_low_byte, {24'h0, v[7:0]}, d);
            bus(1'b1, addr_high_byte, {24'h0, v[15:8]}, d);
            bus(1'b1, addr_control, {28'h0, cmp_m[i]}, d);
            bus(1'b1, addr_status, 32'h2, d);
            pb = pin_out;
            `CHK(pb, cmp_m[i] == mode_cmp_clear)
            // the bench treats the channel pin as an output here
            a0 = adc_cnt;
            far.set_timers(tv, 1'b1);
            f = 1'b0;
            for (int k = 0; k < 40 && f !== 1'b1; k++) begin
                bus(1'b0, addr_status, 32'h0, d);
                f = d[0];
            end
            `CHK(f, 1'b1)
            `CHK(pin_out, exp_pin(cmp_m[i], pb))
            if (cmp_m[i] == mode_cmp_trigger)
                `CHK((sel ? t3 : t1) < 16'd40, 1'b1)
            `CHK(adc_cnt - a0, int'(cmp_m[i] == mode_cmp_trigger && r[17]))
            far.set_timers(16'h0, 1'b0);
        end
        $display("compare test done");
        end_sim();
    end
endmodule : capture_compare_unit_tb_top
